// ===== verilog/port_ctl.sv
// root hub downstream port: reset, overcurrent and suspend/resume control
// assumes an apb master on pclk; link pins come from outside and are synced
//
// How it works
// [RQ1] reset status reads one during reset signalling
// [RQ2] writing one starts reset; zero ignored
// [RQ3] reset to disconnected port sets connect change
// [RQ4] overcurrent reads zero without per-port reporting
// [RQ5] overcurrent bit follows the overcurrent input
// [RQ6] begin-resume acts only while suspended
// [RQ7] suspend set by write, held through resume
// [RQ8] suspend never set while disconnected
// [RQ9] reset end and bus resume clear suspend
// [RQ10] upstream resume forwarded to host controller
// [RQ11] suspend reads zero when idle, one suspended
// [RQ12] reset bit clears as reset change sets
// [RQ13] connected bit shows present attachment
// [RQ14] change flags sticky until software clears
// [RQ15] commands act in one pclk cycle
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "port_ctl_cfg.svh"

module port_ctl
  import port_ctl_pkg::*;
#(
  parameter int reset_cycles  = `RESET_TIME_US * `CLK_MHZ,
  parameter int resume_cycles = `RESUME_TIME_US * `CLK_MHZ
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        device_attached,
  input  wire logic        overcurrent_in,
  input  wire logic        upstream_resume_in,
  output logic             port_reset_drive,
  output logic             port_resume_drive,
  output logic             upstream_resume,
  output logic             irq
);

  localparam int cnt_w = 32;

  // three-stage synchronisers, one per link input
  logic [2:0] sync [3];
  logic [2:0] pin_in;
  logic [2:0] pin_level;

  assign pin_in = {upstream_resume_in, overcurrent_in, device_attached};

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : gen_sync
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          sync[g] <= 3'h0;
        else
          sync[g] <= {sync[g][1:0], pin_in[g]};
      end

      // a change counts once stages two and three agree
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          pin_level[g] <= 1'b0;
        else if (sync[g][1] == sync[g][2])
          pin_level[g] <= sync[g][2];
      end
    end
  endgenerate

  logic port_connected;
  logic oc_level;
  logic up_resume_level;

  assign port_connected  = pin_level[0]; // see [RQ13]
  assign oc_level        = pin_level[1];
  assign up_resume_level = pin_level[2];

  // apb decode; single-cycle access, pready always high
  logic wr_access;
  logic rd_access;
  logic mapped;

  assign wr_access = psel && penable && pwrite;
  assign rd_access = psel && !penable && !pwrite;
  assign mapped    = (paddr == `OFF_PORT_STATUS) || (paddr == `OFF_PORT_CMD)
                  || (paddr == `OFF_IRQ_STATUS) || (paddr == `OFF_IRQ_MASK)
                  || (paddr == `OFF_CONFIG);

  logic cmd_wr;
  logic irq_wr;
  logic start_port_reset_cmd;
  logic set_suspend_cmd;
  logic begin_resume_cmd;

  assign cmd_wr = wr_access && (paddr == `OFF_PORT_CMD);
  assign irq_wr = wr_access && (paddr == `OFF_IRQ_STATUS);
  assign start_port_reset_cmd = cmd_wr && pwdata[`BIT_RESET_ACTIVE]; // see [RQ2]
  assign set_suspend_cmd      = cmd_wr && pwdata[`BIT_SET_SUSPEND];
  assign begin_resume_cmd     = cmd_wr && pwdata[`BIT_BEGIN_RESUME]; // see [RQ6]

  logic [1:0] config_reg;
  logic [4:0] irq_mask;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      config_reg <= `CONFIG_RESET;
    else if (wr_access && paddr == `OFF_CONFIG)
      config_reg <= pwdata[1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_mask <= `MASK_RESET;
    else if (wr_access && paddr == `OFF_IRQ_MASK)
      irq_mask <= pwdata[4:0];
  end

  logic bus_resume_state;
  assign bus_resume_state = config_reg[`BIT_BUS_RESUME];

  // port state machine
  port_state_type state;
  logic [cnt_w-1:0] timer;
  logic reset_done;
  logic resume_done;

  assign reset_done  = (state == port_resetting) && (timer == 32'h0);
  assign resume_done = (state == port_resuming) && (timer == 32'h0);

  // start strobes feed the drives too, so signalling covers exactly the
  // cycles in which the status bit reads one, not one cycle fewer
  logic reset_start;
  logic resume_abort;
  logic resume_start;

  assign reset_start  = start_port_reset_cmd && port_connected
                     && ((state == port_idle) || (state == port_suspend));
  assign resume_abort = bus_resume_state || !port_connected;
  assign resume_start = (state == port_suspend) && begin_resume_cmd
                     && !reset_start && !resume_abort;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= port_idle;
      timer <= 32'h0;
    end
    else
    begin
      unique case (state)
        port_idle:
        begin
          if (reset_start) // see [RQ3] [RQ15]
          begin
            state <= port_resetting;
            timer <= cnt_w'(reset_cycles - 1);
          end
          else if (set_suspend_cmd && port_connected) // see [RQ8]
            state <= port_suspend;
        end
        port_resetting:
        begin
          if (timer != 32'h0)
            timer <= timer - 32'h1;
          else
            state <= port_idle; // see [RQ12]
        end
        port_suspend:
        begin
          if (reset_start)
          begin
            state <= port_resetting;
            timer <= cnt_w'(reset_cycles - 1);
          end
          else if (bus_resume_state || !port_connected)
            state <= port_idle; // see [RQ9]
          else if (begin_resume_cmd) // see [RQ6]
          begin
            state <= port_resuming;
            timer <= cnt_w'(resume_cycles - 1);
          end
        end
        port_resuming:
        begin
          if (bus_resume_state || !port_connected)
            state <= port_idle; // see [RQ9]
          else if (timer != 32'h0)
            timer <= timer - 32'h1;
          else
            state <= port_idle; // see [RQ7]
        end
      endcase
    end
  end

  // a reset taken while suspended keeps suspend visible until the reset
  // change flag sets; otherwise software would see suspend drop early
  logic suspend_in_reset;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      suspend_in_reset <= 1'b0;
    else if (reset_start && (state == port_suspend))
      suspend_in_reset <= 1'b1;
    else if (reset_done || bus_resume_state || !port_connected)
      suspend_in_reset <= 1'b0; // see [RQ9]
  end

  logic port_reset_active;
  logic port_suspended;
  logic port_overcurrent_flag;

  assign port_reset_active     = (state == port_resetting); // see [RQ1]
  assign port_suspended        = (state == port_suspend)
                              || (state == port_resuming)
                              || suspend_in_reset; // see [RQ7] [RQ11]
  assign port_overcurrent_flag = oc_level && config_reg[`BIT_PER_PORT_OC]; // see [RQ4] [RQ5]

  // sticky change flags: set wins over write-one-to-clear
  logic [4:0] change_set;
  logic [4:0] change_flags;
  logic       oc_prev;
  logic       conn_prev;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      oc_prev   <= 1'b0;
      conn_prev <= 1'b0;
    end
    else
    begin
      oc_prev   <= port_overcurrent_flag;
      conn_prev <= port_connected;
    end
  end

  // order: connect, suspend, overcurrent, reset, resume-upstream
  assign change_set[0] = (conn_prev != port_connected)
                      || (start_port_reset_cmd && !port_connected); // see [RQ3]
  assign change_set[1] = resume_done; // see [RQ7]
  assign change_set[2] = port_overcurrent_flag && !oc_prev;
  assign change_set[3] = reset_done; // see [RQ12]
  assign change_set[4] = up_resume_level && port_suspended;

  generate
    for (g = 0; g < 5; g++)
    begin : gen_flag
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          change_flags[g] <= 1'b0;
        else if (change_set[g])
          change_flags[g] <= 1'b1; // see [RQ14]
        else if (irq_wr && pwdata[g])
          change_flags[g] <= 1'b0;
      end
    end
  endgenerate

  logic connect_change_flag;
  logic suspend_change_flag;
  logic reset_change_flag;

  assign connect_change_flag = change_flags[0];
  assign suspend_change_flag = change_flags[1];
  assign reset_change_flag   = change_flags[3];

  logic [31:0] status_word;
  always_comb
  begin
    status_word = 32'h0;
    status_word[`BIT_CONNECTED]    = port_connected;
    status_word[`BIT_SUSPENDED]    = port_suspended;
    status_word[`BIT_OVERCURRENT]  = port_overcurrent_flag;
    status_word[`BIT_RESET_ACTIVE] = port_reset_active;
    status_word[`BIT_RESUMING]     = (state == port_resuming);
    status_word[`BIT_CONNECT_CHG]  = connect_change_flag;
    status_word[`BIT_SUSPEND_CHG]  = suspend_change_flag;
    status_word[`BIT_OVERCUR_CHG]  = change_flags[2];
    status_word[`BIT_RESET_CHG]    = reset_change_flag;
  end

  logic [31:0] next_prdata;
  always_comb
  begin
    unique case (paddr)
      `OFF_PORT_STATUS: next_prdata = status_word;
      `OFF_IRQ_STATUS:  next_prdata = {27'h0, change_flags};
      `OFF_IRQ_MASK:    next_prdata = {27'h0, irq_mask};
      `OFF_CONFIG:      next_prdata = {30'h0, config_reg};
      default:          next_prdata = 32'h0;
    endcase
  end

  // read data captured in setup so it is registered by the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0;
      pslverr <= 1'b0;
      pready  <= 1'b0;
    end
    else
    begin
      pready  <= 1'b1;
      pslverr <= psel && !penable && !mapped;
      if (rd_access)
        prdata <= next_prdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port_reset_drive  <= 1'b0;
      port_resume_drive <= 1'b0;
      upstream_resume   <= 1'b0;
      irq               <= 1'b0;
    end
    else
    begin
      port_reset_drive  <= reset_start || (port_reset_active && !reset_done);
      port_resume_drive <= resume_start
                        || ((state == port_resuming) && !resume_done && !resume_abort);
      upstream_resume   <= up_resume_level && port_suspended; // see [RQ10]
      irq               <= |(change_flags & irq_mask);
    end
  end

endmodule
`default_nettype wire

// ===== verilog/port_ctl_cfg.svh
// register offsets, field positions, reset values and timing counts
// for the root hub port reset / suspend control block
`ifndef PORT_CTL_CFG_SVH
`define PORT_CTL_CFG_SVH

`define OFF_PORT_STATUS   12'h000
`define OFF_PORT_CMD      12'h004
`define OFF_IRQ_STATUS    12'h008
`define OFF_IRQ_MASK      12'h00C
`define OFF_CONFIG        12'h010

// port status / command bit positions
`define BIT_CONNECTED     0
`define BIT_SET_SUSPEND   2
`define BIT_SUSPENDED     2
`define BIT_OVERCURRENT   3
`define BIT_BEGIN_RESUME  3
`define BIT_RESET_ACTIVE  4
`define BIT_RESUMING      5
`define BIT_CONNECT_CHG   16
`define BIT_SUSPEND_CHG   18
`define BIT_OVERCUR_CHG   19
`define BIT_RESET_CHG     20

// config bit positions
`define BIT_PER_PORT_OC   0
`define BIT_BUS_RESUME    1

`define CONFIG_RESET      2'h1
`define MASK_RESET        5'h00

// reset and resume signalling lengths
`define RESET_TIME_US     10
`define RESUME_TIME_US    20
`define CLK_MHZ           125

`endif

// ===== verilog/port_ctl_pkg.sv
// types shared by the port reset / suspend control block
package port_ctl_pkg;

  typedef enum logic [1:0]
  {
    port_idle     = 2'b00,
    port_resetting = 2'b01,
    port_suspend  = 2'b10,
    port_resuming = 2'b11
  } port_state_type;

endpackage

// ===== tb/port_ctl_props.sv
// assertions on the apb side and port drive outputs of port_ctl
// assumes a short reset count passed through the bind
`timescale 1ns/1ns
`default_nettype none
module port_ctl_props
#(
  parameter int reset_cycles = 4
)
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        port_reset_drive,
  input wire logic        port_resume_drive,
  input wire logic        irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  int rst_len;
  // reset run length, counted in high cycles of the drive
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      rst_len <= 0;
    else
      rst_len <= port_reset_drive ? rst_len + 1 : 0;
  AST_READY: assert property ($past(presetn) |-> pready)
    else $error("pready low");
  AST_ERR: assert property (psel && penable && paddr > 12'h010 |-> pslverr)
    else $error("no slave error");
  AST_OK: assert property (psel && penable && paddr <= 12'h010
    && paddr[1:0] == 2'h0 |-> !pslverr) else $error("false slave error");
  AST_RD_ZERO: assert property (psel && penable && !pwrite
    && (paddr == 12'h004 || paddr > 12'h010) |-> prdata == 32'h0) else $error("nonzero read");
  AST_HOLD: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("prdata moved");
  AST_IRQ_OFF: assert property (psel && penable && pwrite && paddr == 12'h00C
    && pwdata[4:0] == 5'h00 |-> ##2 !irq) else $error("irq while masked");
  AST_RST_LEN: assert property ($fell(port_reset_drive)
    |-> rst_len >= reset_cycles && rst_len <= reset_cycles + 1) else $error("reset length");
  AST_RES_END: assert property ($rose(port_resume_drive)
    |-> ##[1:1000] !port_resume_drive) else $error("resume never ends");
  cover property ($fell(port_reset_drive));
  cover property ($fell(port_resume_drive));
  cover property ($rose(irq));
endmodule
bind port_ctl port_ctl_props #(.reset_cycles(reset_cycles)) u_props (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .port_reset_drive(port_reset_drive), .port_resume_drive(port_resume_drive), .irq(irq));
`default_nettype wire

// ===== tb/usb_dev_model.sv
// downstream device: attach, overcurrent and wake pins
// assumes requests come from the bench on pclk edges
`timescale 1ns/1ns
`default_nettype none
module usb_dev_model
(
  input  wire logic pclk,
  input  wire logic attach_req,
  input  wire logic oc_req,
  input  wire logic wake_req,
  output var logic  device_attached,
  output var logic  overcurrent_in,
  output var logic  upstream_resume_in
);
  initial
  begin
    device_attached = 1'h0;
    overcurrent_in = 1'h0;
    upstream_resume_in = 1'h0;
  end
  // pins change one edge late, as a cable would lag the request
  always @(posedge pclk)
  begin
    device_attached <= attach_req;
    overcurrent_in <= oc_req;
    upstream_resume_in <= wake_req;
  end
endmodule
`default_nettype wire

// ===== tb/root_hub_port_reset_suspend_ctl_tb.sv
// testbench for port_ctl: apb driver, read scoreboard, device model
// assumes reset and resume counts shortened to 4 cycles
`timescale 1ns/1ns
`default_nettype none
module root_hub_port_reset_suspend_ctl_tb;
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rnd = 32'hE4F8;
  logic        pready, pslverr, dev_att, oc_in, wake_in, up_res, irq;
  logic        attach_req = 1'h0, oc_req = 1'h0, wake_req = 1'h0;
  logic [63:0] q[$], e;
  int          err_total = 0, samples_checked = 0, cyc = 0;
  always #4 pclk = ~pclk;
  usb_dev_model u_dev (.pclk(pclk), .attach_req(attach_req), .oc_req(oc_req),
    .wake_req(wake_req), .device_attached(dev_att), .overcurrent_in(oc_in),
    .upstream_resume_in(wake_in));
  port_ctl #(.reset_cycles(4), .resume_cycles(4)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .device_attached(dev_att),
    .overcurrent_in(oc_in), .upstream_resume_in(wake_in), .port_reset_drive(),
    .port_resume_drive(), .upstream_resume(up_res), .irq(irq));
  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  function automatic logic [31:0] xorshift(input logic [31:0] v);
    logic [31:0] s;
    s = v ^ (v << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1)
      @(posedge pclk);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic [31:0] m);
    q.push_back({m, x & m});
    apb(1'h0, a, 32'h0);
  endtask
  always @(posedge pclk)
    if (psel && penable && pready === 1'h1 && !pwrite)
    begin
      e = q.pop_front();
      check(prdata & e[63:32], e[31:0]);
    end
  // hang guard: the whole sequence needs well under this
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc > 3000)
    begin
      err_total++;
      end_sim();
    end
  end
  initial
  begin
    tick(5);
    presetn <= 1'h1;
    tick(2);
    rd(12'h010, 32'h1, 32'h3);
    rd(12'h00C, 32'h0, 32'h1F);
    rd(12'h000, 32'h0, 32'h1F003F);
    apb(1'h1, 12'h004, 32'h0);
    rd(12'h000, 32'h0, 32'h10);
    apb(1'h1, 12'h004, 32'h10);
    rd(12'h000, 32'h10000, 32'h10011);
    apb(1'h1, 12'h004, 32'h4);
    rd(12'h000, 32'h0, 32'h4);
    apb(1'h1, 12'h008, 32'h1F);
    rd(12'h008, 32'h0, 32'h1F);
    attach_req <= 1'h1;
    tick(8);
    rd(12'h000, 32'h10001, 32'h10001);
    apb(1'h1, 12'h004, 32'h10);
    rd(12'h000, 32'h11, 32'h11);
    tick(10);
    rd(12'h000, 32'h100001, 32'h100011);
    rnd = xorshift(rnd);
    apb(1'h1, 12'h00C, rnd);
    rd(12'h00C, rnd, 32'h1F);
    apb(1'h1, 12'h00C, 32'h8);
    tick(2);
    check({31'h0, irq}, 32'h1);
    apb(1'h1, 12'h008, 32'h8);
    tick(2);
    check({31'h0, irq}, 32'h0);
    apb(1'h1, 12'h00C, 32'h0);
    apb(1'h1, 12'h004, 32'h4);
    rd(12'h000, 32'h4, 32'h24);
    apb(1'h1, 12'h004, 32'h8);
    rd(12'h000, 32'h24, 32'h24);
    tick(10);
    rd(12'h000, 32'h40000, 32'h40024);
    apb(1'h1, 12'h004, 32'h8);
    rd(12'h000, 32'h0, 32'h24);
    apb(1'h1, 12'h004, 32'h4);
    apb(1'h1, 12'h010, 32'h3);
    rd(12'h000, 32'h0, 32'h4);
    apb(1'h1, 12'h010, 32'h1);
    apb(1'h1, 12'h004, 32'h4);
    apb(1'h1, 12'h004, 32'h10);
    rd(12'h000, 32'h14, 32'h14);
    tick(10);
    rd(12'h000, 32'h0, 32'h4);
    apb(1'h1, 12'h004, 32'h4);
    wake_req <= 1'h1;
    tick(8);
    check({31'h0, up_res}, 32'h1);
    wake_req <= 1'h0;
    oc_req <= 1'h1;
    tick(8);
    rd(12'h000, 32'h8, 32'h8);
    apb(1'h1, 12'h010, 32'h0);
    rd(12'h000, 32'h0, 32'h8);
    apb(1'h1, 12'h010, 32'h1);
    oc_req <= 1'h0;
    tick(8);
    rd(12'h000, 32'h0, 32'h8);
    rnd = xorshift(rnd);
    rd({1'h1, rnd[10:2], 2'h0}, 32'h0, 32'hFFFFFFFF);
    rd(12'h004, 32'h0, 32'hFFFFFFFF);
    attach_req <= 1'h0;
    tick(8);
    rd(12'h000, 32'h0, 32'h5);
    end_sim();
  end
endmodule
`default_nettype wire
